/* File: src/fault_latch_spi_capture.sv */
// Top: serial frame capture, fault and status flags, and six channel fault latches.
`timescale 1ns/1ps
`default_nettype none
module fault_latch_spi_capture #(
   parameter int NUM_CHANNELS = fault_capture_pkg::NUM_CHANNELS,
   parameter int FRAME_BITS = fault_capture_pkg::FRAME_BITS,
   parameter int RETRY_CYCLES = fault_capture_pkg::RETRY_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic master_enable_first_i,
   input wire logic master_enable_second_i,
   input wire logic [NUM_CHANNELS-1:0] cmd_on_i,
   input wire logic [2*NUM_CHANNELS-1:0] drain_zone_i,
   input wire logic chip_select_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic [NUM_CHANNELS-1:0] gate_drive_out_o,
   output logic fault_flag_n_o,
   output logic fault_flag_n_oe_n_o,
   output logic status_flag_n_o,
   output logic status_flag_n_oe_n_o,
   output logic [FRAME_BITS-1:0] config_data_o,
   output logic config_write_o
);
   initial
   begin
      if (2 * NUM_CHANNELS > FRAME_BITS)
         $error("fault_latch_spi_capture: fault fields do not fit the frame");
   end

   localparam int CW = fault_capture_pkg::FRAME_CNT_W;

   // Two-flop synchronisers for every pin input.
   logic [2:0] pins_s1_reg;
   logic [2:0] pins_s2_reg;
   logic [1:0] ena_s1_reg;
   logic [1:0] ena_s2_reg;
   logic [NUM_CHANNELS-1:0] cmd_s1_reg;
   logic [NUM_CHANNELS-1:0] cmd_s2_reg;
   logic [2*NUM_CHANNELS-1:0] zone_s1_reg;
   logic [2*NUM_CHANNELS-1:0] zone_s2_reg;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         pins_s1_reg <= 3'h1;
         pins_s2_reg <= 3'h1;
         ena_s1_reg <= 2'h0;
         ena_s2_reg <= 2'h0;
         cmd_s1_reg <= '0;
         cmd_s2_reg <= '0;
         zone_s1_reg <= '0;
         zone_s2_reg <= '0;
      end
      else
      begin
         pins_s1_reg <= {serial_in_i, serial_clk_i, chip_select_n_i};
         pins_s2_reg <= pins_s1_reg;
         ena_s1_reg <= {master_enable_second_i, master_enable_first_i};
         ena_s2_reg <= ena_s1_reg;
         cmd_s1_reg <= cmd_on_i;
         cmd_s2_reg <= cmd_s1_reg;
         zone_s1_reg <= drain_zone_i;
         zone_s2_reg <= zone_s1_reg;
      end
   end

   // Delayed copies for edge detection, taken from the second stage only.
   logic cs_d_reg;
   logic sck_d_reg;
   logic [1:0] ena_d_reg;
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cs_d_reg <= 1'b1;
         sck_d_reg <= 1'b0;
         ena_d_reg <= 2'h0;
      end
      else
      begin
         cs_d_reg <= pins_s2_reg[0];
         sck_d_reg <= pins_s2_reg[1];
         ena_d_reg <= ena_s2_reg;
      end
   end

   wire logic cs_n = pins_s2_reg[0];
   wire logic sck = pins_s2_reg[1];
   wire logic sdi = pins_s2_reg[2];
   wire logic master_enable_first = ena_s2_reg[0];
   wire logic master_enable_second = ena_s2_reg[1];
   wire logic cs_fall = cs_d_reg && !cs_n;
   wire logic cs_rise = !cs_d_reg && cs_n;
   wire logic sck_rise = !sck_d_reg && sck && !cs_n;
   wire logic sck_fall = sck_d_reg && !sck && !cs_n;
   wire logic enabled = master_enable_first && master_enable_second;
   wire logic enable_rise = enabled && !(ena_d_reg[0] && ena_d_reg[1]);
   wire logic master_enable_first_rise = master_enable_first && !ena_d_reg[0];

   // Frame length check and the shift register.
   logic [CW-1:0] bit_cnt_reg;
   logic over_reg;
   logic [FRAME_BITS-1:0] shift_reg;
   logic [FRAME_BITS-1:0] config_reg;
   logic config_write_reg;
   logic master_enable_first_low_seen_reg;
   wire logic frame_valid = cs_rise && !over_reg
      && (bit_cnt_reg == CW'(FRAME_BITS));

   // Fault fields from every channel, packed channel 0 in the low bits.
   wire logic [2*NUM_CHANNELS-1:0] latch_codes;
   wire logic [NUM_CHANNELS-1:0] latch_full;
   wire logic [FRAME_BITS-1:0] fault_word = FRAME_BITS'(latch_codes);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         bit_cnt_reg <= fault_capture_pkg::FRAME_CNT_RESET;
         over_reg <= 1'b0;
         shift_reg <= fault_capture_pkg::SHIFT_RESET;
      end
      else if (cs_fall)
      begin
         bit_cnt_reg <= fault_capture_pkg::FRAME_CNT_RESET;
         over_reg <= 1'b0;
         shift_reg <= fault_word;
      end
      else if (sck_rise)
      begin
         shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi};
         if (bit_cnt_reg == CW'(FRAME_BITS))
            over_reg <= 1'b1;
         else
            bit_cnt_reg <= bit_cnt_reg + CW'(1);
      end
   end

   // Serial output changes on the falling serial clock, most significant bit first.
   logic sdo_reg;
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         sdo_reg <= 1'b0;
      else if (cs_fall)
         sdo_reg <= fault_word[FRAME_BITS-1];
      else if (sck_fall)
         sdo_reg <= shift_reg[FRAME_BITS-1];
   end

   // Configuration data is taken only from a valid frame.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         config_reg <= fault_capture_pkg::SHIFT_RESET;
         config_write_reg <= 1'b0;
      end
      else
      begin
         config_write_reg <= frame_valid;
         if (frame_valid)
            config_reg <= shift_reg;
      end
   end

   // Track the low phase of master_enable_first for the high-low-high clear.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         master_enable_first_low_seen_reg <= 1'b0;
      else if (!master_enable_first)
         master_enable_first_low_seen_reg <= 1'b1;
      else if (master_enable_first_rise)
         master_enable_first_low_seen_reg <= 1'b0;
   end

   // Re-arm on a valid frame end or on the enable toggle.
   wire logic rearm = frame_valid || (master_enable_first_rise && master_enable_first_low_seen_reg);

   // Flag holds released from chip select fall until the frame ends.
   logic flag_hold_reg;
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         flag_hold_reg <= 1'b0;
      else if (cs_fall)
         flag_hold_reg <= 1'b1;
      else if (cs_rise || !master_enable_first)
         flag_hold_reg <= 1'b0;
   end

   // One channel instance per channel.
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++)
      begin : g_ch
         fault_channel #(
            .RETRY_CYCLES(RETRY_CYCLES)
         ) u_ch (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .enabled_i(enabled),
            .enable_rise_i(enable_rise),
            .cmd_on_i(cmd_s2_reg[ch]),
            .zone_i(zone_s2_reg[2*ch+1:2*ch]),
            .rearm_i(rearm),
            .gate_drive_out_o(gate_drive_out_o[ch]),
            .latch_code_o(latch_codes[2*ch+1:2*ch]),
            .latch_full_o(latch_full[ch])
         );
      end
   endgenerate

   // Flags registered; fault flag off while enable or chip select is low.
   logic fault_n_reg;
   logic status_n_reg;
   wire logic [NUM_CHANNELS-1:0] below_open;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++)
      begin : g_st
         assign below_open[ch] = zone_s2_reg[2*ch+1:2*ch] != fault_capture_pkg::ZONE_GOOD
            && zone_s2_reg[2*ch+1:2*ch] != fault_capture_pkg::ZONE_SHORT;
      end
   endgenerate
   wire logic fault_on = master_enable_first && cs_n && !flag_hold_reg && !rearm && (|latch_full);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         fault_n_reg <= 1'b1;
         status_n_reg <= 1'b1;
      end
      else
      begin
         fault_n_reg <= !fault_on;
         status_n_reg <= !(master_enable_first && (|below_open));
      end
   end

   // Open-drain pins: enable low means the pin is pulled low.
   assign fault_flag_n_o = 1'b0;
   assign fault_flag_n_oe_n_o = fault_n_reg;
   assign status_flag_n_o = 1'b0;
   assign status_flag_n_oe_n_o = status_n_reg;
   assign serial_out_o = sdo_reg;
   assign config_data_o = config_reg;
   assign config_write_o = config_write_reg;
endmodule : fault_latch_spi_capture
`default_nettype wire

/* File: src/fault_capture_pkg.sv */
// Package with constants shared by the fault capture block and its channel module.
`default_nettype none
package fault_capture_pkg;
   localparam int NUM_CHANNELS = 6;
   localparam int FRAME_BITS = 16;
   localparam int CLK_PERIOD_NS = 50;
   // Fault codes per channel.
   localparam logic [1:0] CODE_NONE = 2'h0;
   localparam logic [1:0] CODE_OPEN = 2'h1;
   localparam logic [1:0] CODE_GND = 2'h2;
   localparam logic [1:0] CODE_SHORT = 2'h3;
   // Drain comparison zones.
   localparam logic [1:0] ZONE_GOOD = 2'h0;
   localparam logic [1:0] ZONE_OPEN = 2'h1;
   localparam logic [1:0] ZONE_GND = 2'h2;
   localparam logic [1:0] ZONE_SHORT = 2'h3;
   // Timer figures in microseconds and derived cycle counts.
   localparam int BLANK_TIME_US = 10;
   localparam int FILTER_TIME_US = 5;
   localparam int RETRY_TIME_US = 10000;
   localparam int BLANK_CYCLES = (BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_CYCLES = (FILTER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RETRY_CYCLES = (RETRY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 20;
   localparam int FRAME_CNT_W = 5;
   localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_RESET = 5'h00;
   localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
endpackage : fault_capture_pkg
`default_nettype wire

/* File: src/fault_channel.sv */
// One channel: drain zone timing, gate control with auto-retry and the fault latch.
`timescale 1ns/1ps
`default_nettype none
module fault_channel #(
   parameter int BLANK_CYCLES = fault_capture_pkg::BLANK_CYCLES,
   parameter int FILTER_CYCLES = fault_capture_pkg::FILTER_CYCLES,
   parameter int RETRY_CYCLES = fault_capture_pkg::RETRY_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic enabled_i,
   input wire logic enable_rise_i,
   input wire logic cmd_on_i,
   input wire logic [1:0] zone_i,
   input wire logic rearm_i,
   output logic gate_drive_out_o,
   output logic [1:0] latch_code_o,
   output logic latch_full_o
);
   localparam int TW = fault_capture_pkg::TIMER_W;

   initial
   begin
      if (BLANK_CYCLES < 1 || FILTER_CYCLES < 1 || RETRY_CYCLES < 1 ||
          RETRY_CYCLES >= (1 << TW))
         $error("fault_channel: timer counts out of range");
   end

   logic cmd_reg;
   logic [1:0] zone_reg;
   logic [TW-1:0] blank_reg;
   logic [TW-1:0] filt_reg;
   logic [TW-1:0] retry_reg;
   logic retrying_reg;
   logic gate_reg;
   logic [1:0] code_reg;
   logic full_reg;
   logic [1:0] status_reg;

   // Zone to code: short only counts when on, ground and open only when off.
   wire logic [1:0] zone_code = cmd_on_i ?
      ((zone_i == fault_capture_pkg::ZONE_SHORT) ? fault_capture_pkg::CODE_SHORT
                                                 : fault_capture_pkg::CODE_NONE) :
      ((zone_i == fault_capture_pkg::ZONE_GND) ? fault_capture_pkg::CODE_GND :
       (zone_i == fault_capture_pkg::ZONE_OPEN) ? fault_capture_pkg::CODE_OPEN :
       fault_capture_pkg::CODE_NONE);
   wire logic cmd_change = enabled_i && (cmd_on_i != cmd_reg);
   wire logic zone_change = enabled_i && (zone_i != zone_reg)
      && (zone_i != fault_capture_pkg::ZONE_GOOD);
   wire logic blank_end = (blank_reg == TW'(1));
   wire logic filt_end = (filt_reg == TW'(1));
   wire logic timer_busy = (blank_reg != '0) || (filt_reg != '0);
   wire logic retry_end = retrying_reg && (retry_reg == TW'(1));
   // A capture only happens on the final tick of a timer, never while one still runs.
   wire logic timer_busy_after = (blank_reg > TW'(1)) || (filt_reg > TW'(1));
   wire logic detect = (blank_end || filt_end) && !timer_busy_after;
   wire logic short_hit = detect && cmd_on_i && zone_code == fault_capture_pkg::CODE_SHORT;
   wire logic start_blank = cmd_change || enable_rise_i || (retry_end && cmd_on_i);
   // A return to the good zone starts no timer, so the status clears once timers are idle.
   wire logic status_idle = !timer_busy && (zone_code == fault_capture_pkg::CODE_NONE);
   wire logic [1:0] status_next = detect ? zone_code :
      (status_idle ? fault_capture_pkg::CODE_NONE : status_reg);

   // Comparison history and commanded state.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || !enabled_i)
      begin
         cmd_reg <= 1'b0;
         zone_reg <= fault_capture_pkg::ZONE_GOOD;
      end
      else
      begin
         cmd_reg <= cmd_on_i;
         zone_reg <= zone_i;
      end
   end

   // Blanking and filter timers count down to zero.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || !enabled_i)
      begin
         blank_reg <= '0;
         filt_reg <= '0;
      end
      else
      begin
         blank_reg <= start_blank ? TW'(BLANK_CYCLES) : (blank_reg != '0 ? blank_reg - TW'(1) : '0);
         filt_reg <= (zone_change || (retry_end && cmd_on_i)) ? TW'(FILTER_CYCLES) :
                     (filt_reg != '0 ? filt_reg - TW'(1) : '0);
      end
   end

   // Gate and auto-retry: a short drops the gate and arms the retry timer.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || !enabled_i)
      begin
         gate_reg <= 1'b0;
         retrying_reg <= 1'b0;
         retry_reg <= '0;
      end
      else if (!cmd_on_i)
      begin
         gate_reg <= 1'b0;
         retrying_reg <= 1'b0;
         retry_reg <= '0;
      end
      else if (short_hit)
      begin
         gate_reg <= 1'b0;
         retrying_reg <= 1'b1;
         retry_reg <= TW'(RETRY_CYCLES);
      end
      else if (retry_end)
      begin
         gate_reg <= 1'b1;
         retrying_reg <= 1'b0;
         retry_reg <= '0;
      end
      else
      begin
         gate_reg <= !retrying_reg;
         retry_reg <= (retry_reg != '0) ? retry_reg - TW'(1) : '0;
      end
   end

   // Current status follows timer ends; the latch holds the first captured fault.
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || !enabled_i)
      begin
         status_reg <= fault_capture_pkg::CODE_NONE;
         code_reg <= fault_capture_pkg::CODE_NONE;
         full_reg <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         if (rearm_i)
         begin
            // Re-arm takes this cycle's status, so a fault found on the same edge is kept.
            code_reg <= status_next;
            full_reg <= (status_next != fault_capture_pkg::CODE_NONE);
         end
         else if (!full_reg && detect && zone_code != fault_capture_pkg::CODE_NONE)
         begin
            code_reg <= zone_code;
            full_reg <= 1'b1;
         end
         // Once full the latch ignores further codes until a re-arm.
      end
   end

   assign gate_drive_out_o = gate_reg;
   assign latch_code_o = code_reg;
   assign latch_full_o = full_reg;
endmodule : fault_channel
`default_nettype wire

/* File: test/fault_capture_asserts.sv */
// Concurrent checks on the ports of the fault capture block.
`timescale 1ns/1ps
`default_nettype none
module fault_capture_asserts #(
   parameter int NUM_CHANNELS = 6,
   parameter int FRAME_BITS = 16
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic master_enable_first_i,
   input wire logic master_enable_second_i,
   input wire logic [NUM_CHANNELS-1:0] cmd_on_i,
   input wire logic [2*NUM_CHANNELS-1:0] drain_zone_i,
   input wire logic chip_select_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   input wire logic serial_out_o,
   input wire logic [NUM_CHANNELS-1:0] gate_drive_out_o,
   input wire logic fault_flag_n_o,
   input wire logic fault_flag_n_oe_n_o,
   input wire logic status_flag_n_o,
   input wire logic status_flag_n_oe_n_o,
   input wire logic [FRAME_BITS-1:0] config_data_o,
   input wire logic config_write_o
);
   logic [NUM_CHANNELS-1:0] low_zone;
   logic any_low;
   // Open and ground zones are the two codes whose zone bits differ.
   for (genvar g = 0; g < NUM_CHANNELS; g++)
   begin : g_zone
      assign low_zone[g] = drain_zone_i[2*g+1] ^ drain_zone_i[2*g];
   end
   assign any_low = |low_zone;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // Windows of five cycles absorb the two-flop synchronisers on the pins.
   a_reset_state: assert property ($fell(rst_i) |-> gate_drive_out_o == '0 &&
      fault_flag_n_oe_n_o && status_flag_n_oe_n_o && config_data_o == '0)
      else $error("outputs not at reset values");
   a_drain_pins_low: assert property (!fault_flag_n_o && !status_flag_n_o)
      else $error("open-drain data not low");
   a_enable_off_quiet: assert property ((!master_enable_first_i)[*5] |->
      fault_flag_n_oe_n_o && status_flag_n_oe_n_o && gate_drive_out_o == '0)
      else $error("flags or gates active with enable low");
   a_select_release: assert property ((!chip_select_n_i)[*5] |-> fault_flag_n_oe_n_o)
      else $error("fault flag held during frame");
   a_status_set: assert property ((master_enable_first_i && any_low)[*5] |->
      !status_flag_n_oe_n_o) else $error("status flag not set");
   a_status_clear: assert property ((!any_low)[*5] |-> status_flag_n_oe_n_o)
      else $error("status flag not released");
   a_write_single: assert property (config_write_o |=> !config_write_o)
      else $error("write pulse longer than one cycle");
   a_config_cause: assert property ($changed(config_data_o) |->
      $past(config_write_o) or ##[0:1] config_write_o)
      else $error("config data changed without write");
   a_write_after_rise: assert property (config_write_o |->
      chip_select_n_i && $past(chip_select_n_i, 2)) else $error("write without frame end");
   a_gate_needs_cmd: assert property ((cmd_on_i == '0)[*5] |-> gate_drive_out_o == '0)
      else $error("gate on while not commanded");

   c_fault_flag: cover property (!fault_flag_n_oe_n_o);
   c_config_write: cover property (config_write_o);
   c_gate_retry: cover property ($rose(gate_drive_out_o[0]));
endmodule : fault_capture_asserts

bind fault_latch_spi_capture fault_capture_asserts #(
   .NUM_CHANNELS(NUM_CHANNELS), .FRAME_BITS(FRAME_BITS)
) u_asserts (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .master_enable_first_i(master_enable_first_i),
   .master_enable_second_i(master_enable_second_i), .cmd_on_i(cmd_on_i),
   .drain_zone_i(drain_zone_i), .chip_select_n_i(chip_select_n_i),
   .serial_clk_i(serial_clk_i), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
   .gate_drive_out_o(gate_drive_out_o), .fault_flag_n_o(fault_flag_n_o),
   .fault_flag_n_oe_n_o(fault_flag_n_oe_n_o), .status_flag_n_o(status_flag_n_o),
   .status_flag_n_oe_n_o(status_flag_n_oe_n_o), .config_data_o(config_data_o),
   .config_write_o(config_write_o)
);
`default_nettype wire

/* File: test/host_link_model.sv */
// Host link controller model that runs serial frames against the block.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   input wire logic clk_sys_i,
   input wire logic sdo_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic sdi_o
);
   logic in_frame = 1'b0;
   initial
   begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   // Released data line toggles so that a stale bit is never mistaken for data.
   always @(posedge clk_sys_i) if (!in_frame) sdi_o <= ~sdi_o;
   // Sends nbits MSB first, each clock phase four cycles; reads back just before each fall.
   task automatic xfer(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clk_sys_i);
      in_frame <= 1'b1;
      cs_n_o <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      for (int i = 0; i < nbits; i++)
      begin
         sdi_o <= tx[15 - i];
         repeat (4) @(posedge clk_sys_i);
         sck_o <= 1'b1;
         repeat (4) @(posedge clk_sys_i);
         rx = {rx[14:0], sdo_i};
         sck_o <= 1'b0;
      end
      repeat (4) @(posedge clk_sys_i);
      cs_n_o <= 1'b1;
      in_frame <= 1'b0;
   endtask : xfer
endmodule : host_link_model
`default_nettype wire

/* File: test/fault_latch_spi_capture_tb.sv */
// Self-checking testbench for the fault capture block.
`timescale 1ns/1ps
`default_nettype none
module fault_latch_spi_capture_tb;
   localparam int RETRY = 50;
   localparam int BLANK = fault_capture_pkg::BLANK_CYCLES;
   localparam int FILT = fault_capture_pkg::FILTER_CYCLES;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic master_enable_first = 1'b0;
   logic master_enable_second = 1'b0;
   logic [5:0] cmd = 6'h00;
   logic [11:0] zone = 12'h000;
   wire cs_n, sck, sdi;
   logic sdo, flt_n, flt_oe_n, sta_n, sta_oe_n, cfg_wr;
   logic [5:0] gate;
   logic [15:0] cfg, rx;
   int n_errors = 0;
   int tests_run = 0;
   int n_writes = 0;

   always #25 clk_sys_i = ~clk_sys_i;
   // Counts write pulses so a refused frame can be told from a taken one.
   always @(posedge clk_sys_i) if (cfg_wr === 1'b1) n_writes <= n_writes + 1;

   fault_latch_spi_capture #(.RETRY_CYCLES(RETRY)) u_dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .master_enable_first_i(master_enable_first),
      .master_enable_second_i(master_enable_second), .cmd_on_i(cmd), .drain_zone_i(zone),
      .chip_select_n_i(cs_n), .serial_clk_i(sck), .serial_in_i(sdi), .serial_out_o(sdo),
      .gate_drive_out_o(gate), .fault_flag_n_o(flt_n), .fault_flag_n_oe_n_o(flt_oe_n),
      .status_flag_n_o(sta_n), .status_flag_n_oe_n_o(sta_oe_n), .config_data_o(cfg),
      .config_write_o(cfg_wr));
   host_link_model u_host (.clk_sys_i(clk_sys_i), .sdo_i(sdo), .cs_n_o(cs_n),
      .sck_o(sck), .sdi_o(sdi));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   // Waits a bounded time for a gate (sel below 6) or the fault flag enable to reach want.
   task automatic wait_bit(input string what, input int sel, input logic want, input int lim);
      logic v;
      for (int k = 0; k < lim; k++)
      begin
         @(negedge clk_sys_i);
         v = (sel < 6) ? gate[sel] : flt_oe_n;
         if (v === want) break;
      end
      check(what, {15'h0000, v}, {15'h0000, want});
   endtask : wait_bit

   // One frame, then time for the frame-end detect and write pulse to land.
   task automatic frame(input int nbits, input logic [15:0] tx);
      u_host.xfer(nbits, tx, rx);
      repeat (8) @(posedge clk_sys_i);
   endtask : frame

   task automatic s_reset;
      @(negedge clk_sys_i);
      check("gates", {10'h000, gate}, 16'h0000);
      check("flags", {14'h0000, flt_oe_n, sta_oe_n}, 16'h0003);
      check("config", cfg, 16'h0000);
      check("drain pins", {14'h0000, flt_n, sta_n}, 16'h0000);
      @(posedge clk_sys_i);
      rst_i <= 1'b0;
      zone <= 12'h008;
      repeat (4) @(posedge clk_sys_i);
      master_enable_first <= 1'b1;
      master_enable_second <= 1'b1;
   endtask : s_reset

   // Channel 1 goes ground, then open, then good; the first read after the open and good changes shows the older latched code.
   task automatic s_ground_open;
      wait_bit("flag ground", 6, 1'b0, BLANK + 20);
      check("status set", {15'h0000, sta_oe_n}, 16'h0000);
      frame(16, 16'h1234);
      check("ground code", rx, 16'h0008);
      check("config", cfg, 16'h1234);
      check("writes", n_writes[15:0], 16'h0001);
      wait_bit("flag recaptured", 6, 1'b0, 10);
      zone <= 12'h004;
      repeat (FILT + 20) @(posedge clk_sys_i);
      frame(16, 16'h4321);
      check("code held", rx, 16'h0008);
      frame(16, 16'h4321);
      check("open code", rx, 16'h0004);
      zone <= 12'h000;
      repeat (FILT + 20) @(posedge clk_sys_i);
      frame(16, 16'h0F0F);
      check("open held", rx, 16'h0004);
      wait_bit("flag cleared", 6, 1'b1, 10);
      frame(16, 16'h0F0F);
      check("no fault", rx, 16'h0000);
      check("status clear", {15'h0000, sta_oe_n}, 16'h0001);
   endtask : s_ground_open

   // A 15-clock frame must be refused and leave the latch alone.
   task automatic s_invalid;
      int w;
      zone <= 12'h008;
      wait_bit("flag filter", 6, 1'b0, FILT + 30);
      w = n_writes;
      frame(15, 16'hBEEF);
      check("no write", 16'(n_writes - w), 16'h0000);
      check("config kept", cfg, 16'h0F0F);
      wait_bit("flag kept", 6, 1'b0, 2);
      frame(16, 16'h0F0F);
      check("kept code", rx, 16'h0008);
   endtask : s_invalid

   task automatic s_enable_pulse;
      master_enable_first <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check("flags off", {14'h0000, flt_oe_n, sta_oe_n}, 16'h0003);
      @(posedge clk_sys_i);
      master_enable_first <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      frame(16, 16'h0F0F);
      check("cleared", rx, 16'h0000);
      wait_bit("flag back", 6, 1'b0, BLANK + 20);
      zone <= 12'h000;
      frame(16, 16'h0F0F);
      wait_bit("flag released", 6, 1'b1, 10);
   endtask : s_enable_pulse

   // Channel 0 on into a shorted load: drop, retry, drop again, then read the code.
   task automatic s_short;
      zone <= 12'h003;
      cmd <= 6'h01;
      wait_bit("gate on", 0, 1'b1, 10);
      wait_bit("gate off", 0, 1'b0, BLANK + FILT + 20);
      wait_bit("retry on", 0, 1'b1, RETRY + 20);
      wait_bit("retry off", 0, 1'b0, BLANK + 20);
      wait_bit("flag short", 6, 1'b0, 10);
      frame(16, 16'h0F0F);
      check("short code", rx, 16'h0003);
      cmd <= 6'h00;
      zone <= 12'h000;
   endtask : s_short

   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      s_reset();
      s_ground_open();
      s_invalid();
      s_enable_pulse();
      s_short();
      finish_test();
   end

   // The scenarios need about 2600 cycles; a hang is cut off well beyond that.
   initial
   begin
      repeat (30000) @(posedge clk_sys_i);
      n_errors++;
      finish_test();
   end
endmodule : fault_latch_spi_capture_tb
`default_nettype wire
